// ===== audio_clk_map.vh
// Register map, field positions, reset values and timing counts of the serial audio clocking block.
// Assumes byte addresses on an APB3 bus with 32-bit data, one aligned word per register.
`ifndef AUDIO_CLK_MAP_VH
`define AUDIO_CLK_MAP_VH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define CTRL_OFS 8'h00
`define TX_CFG_OFS 8'h04
`define RX_CFG_OFS 8'h08
`define RES_OFS 8'h0C
`define STATUS_OFS 8'h10
`define FRAMES_OFS 8'h14

// ***************************************************************
// Field positions
// ***************************************************************
`define CTRL_MDIR_MSB 1
`define CTRL_MDIR_LSB 0
`define CTRL_DRIVE 2
`define CTRL_LEVEL_MSB 4
`define CTRL_LEVEL_LSB 3
`define CFG_BITS_MSB 5
`define CFG_BITS_LSB 0
`define CFG_BDIR 6
`define CFG_PULSE 7
`define CFG_EDGE 8
`define CFG_INV 9
`define CFG_CHAN_MSB 24
`define CFG_CHAN_LSB 16
`define RES_TX_MSB 5
`define RES_TX_LSB 0
`define RES_RX_MSB 13
`define RES_RX_LSB 8

// ***************************************************************
// Encodings, limits and reset values
// ***************************************************************
`define MDIR_BOTH_IN 2'h0
`define MDIR_TX_OUT 2'h1
`define MDIR_RX_OUT 2'h2
`define BITS_MIN 6'h08
`define BITS_MAX 6'h20
`define CHAN_MIN 9'h001
`define CHAN_MAX 9'h100
`define BITS_RST 6'h20
`define CHAN_RST 9'h002
`define RES_RST 6'h10

// ***************************************************************
// Timing counts
// ***************************************************************
`define BCLK_HALF_LAST 3'h3

`endif

// ===== bit_sync.v
// Two-flop synchronisers, one per pin input.
// Assumes the inputs are asynchronous to clk; nothing reads the first stage.
module bit_sync #(
   parameter WIDTH = 5
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Asynchronous inputs and synchronised levels
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_ff[i] <= 1'b0;
               sync_ff[i] <= 1'b0;
            end else begin
               meta_ff[i] <= async_in[i];
               sync_ff[i] <= meta_ff[i];
            end
         end
      end
   endgenerate

   assign sync_out = sync_ff;

endmodule // bit_sync

// ===== side_engine.v
// Bit, subframe and frame counting with channel clock shaping for one side.
// Assumes bit_event is a one-cycle pulse per chosen bit clock edge.
`include "audio_clk_map.vh"
module side_engine (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Bit clock edge and incoming channel clock
   input wire bit_event,
   input wire align_en,
   input wire chclk_smp,
   // Configuration
   input wire [5:0] bits_per_subframe,
   input wire [8:0] channels_per_frame,
   input wire channel_pulse_width_select,
   input wire channel_clock_polarity_invert,
   // State
   output wire chclk_out,
   output wire [4:0] bit_idx,
   output wire [7:0] sub_idx,
   output wire frame_pulse
);

   reg started_ff;
   reg prev_smp_ff;
   reg chclk_ff;
   reg frame_ff;
   reg [4:0] bit_ff;
   reg [7:0] sub_ff;
   wire [4:0] last_bit;
   wire [7:0] last_sub;
   wire start_lvl;
   wire align_hit;
   wire bit_wrap;
   wire sub_wrap;
   wire [4:0] nxt_bit;
   wire [7:0] nxt_sub;
   wire [5:0] half_bits;
   wire nxt_high;

   // 32 and 256 wrap to zero in the low bits, so minus one gives 31 and 255
   assign last_bit = bits_per_subframe[4:0] - 5'h01;
   assign last_sub = channels_per_frame[7:0] - 8'h01;
   assign start_lvl = ~channel_clock_polarity_invert;
   // Receive side realigns on the start-of-subframe transition
   assign align_hit = align_en & (chclk_smp == start_lvl) & (prev_smp_ff != start_lvl);
   // Counters beyond a newly shrunk limit wrap at once instead of running away
   assign bit_wrap = ~started_ff | align_hit | (bit_ff >= last_bit);
   assign nxt_bit = bit_wrap ? 5'h00 : bit_ff + 5'h01;
   assign sub_wrap = ~started_ff | (sub_ff >= last_sub);
   assign nxt_sub = sub_wrap ? 8'h00 : sub_ff + 8'h01;
   // (B-1)/2 for odd B and B/2 for even B are both B shifted right once
   assign half_bits = bits_per_subframe >> 1;
   assign nxt_high = channel_pulse_width_select ? (nxt_bit == 5'h00) :
                     ({1'b0, nxt_bit} < half_bits);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         started_ff <= 1'b0;
         prev_smp_ff <= 1'b0;
         chclk_ff <= 1'b0;
         frame_ff <= 1'b0;
         bit_ff <= 5'h00;
         sub_ff <= 8'h00;
      end else begin
         frame_ff <= 1'b0;
         if (bit_event) begin
            started_ff <= 1'b1;
            prev_smp_ff <= chclk_smp;
            bit_ff <= nxt_bit;
            chclk_ff <= nxt_high ^ channel_clock_polarity_invert;
            if (bit_wrap) begin
               sub_ff <= nxt_sub;
               frame_ff <= sub_wrap & started_ff;
            end
         end
      end
   end

   assign chclk_out = chclk_ff;
   assign bit_idx = bit_ff;
   assign sub_idx = sub_ff;
   assign frame_pulse = frame_ff;

endmodule // side_engine

// ===== audio_clock_top.v
// Serial audio port clocking for a transmit and a receive side, with an APB3 register slave.
// Assumes pins pass through two flops; bit clocks from outside run well below pclk/4.
`include "audio_clk_map.vh"
module audio_clock_top (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Transmit master clock
   input wire tx_mclk_i,
   output wire tx_mclk_o,
   output wire tx_mclk_oe,
   // Receive master clock
   input wire rx_mclk_i,
   output wire rx_mclk_o,
   output wire rx_mclk_oe,
   // Transmit bit clock
   input wire tx_bclk_i,
   output wire tx_bclk_o,
   output wire tx_bclk_oe,
   // Receive bit clock
   input wire rx_bclk_i,
   output wire rx_bclk_o,
   output wire rx_bclk_oe,
   // Channel clocks
   output wire tx_chclk_o,
   output wire tx_chclk_oe,
   input wire rx_chclk_i,
   // Pad level select
   output wire [1:0] output_level_select
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   reg [1:0] master_clock_direction_select_ff;
   reg output_drive_enable_ff;
   reg [1:0] level_ff;
   reg [5:0] tx_bits_ff, rx_bits_ff;
   reg [8:0] tx_chans_ff, rx_chans_ff;
   reg tx_bdir_ff, rx_bdir_ff;
   reg tx_pulse_ff, rx_pulse_ff;
   reg tx_edge_ff, rx_edge_ff;
   reg tx_inv_ff, rx_inv_ff;
   reg [5:0] tx_res_ff, rx_res_ff;
   reg [31:0] prdata_ff;
   reg pready_ff, pslverr_ff;
   reg mclk_gen_ff;
   reg [2:0] bdiv_ff;
   reg bgen_ff;
   reg [4:0] dly_ff;
   reg [1:0] mclk_seen_ff;
   reg [15:0] tx_frames_ff, rx_frames_ff;
   reg tx_mclk_oe_ff, rx_mclk_oe_ff;
   reg tx_bclk_oe_ff, rx_bclk_oe_ff;
   reg tx_chclk_oe_ff;
   reg [31:0] nxt_rdata;
   reg nxt_mapped, nxt_bad;
   wire [4:0] pins_s;
   wire setup_ph, access_ph;
   wire [5:0] w_bits;
   wire [8:0] w_chans;
   wire [5:0] w_res_tx, w_res_rx;
   wire tx_bits_ok, rx_bits_ok;
   wire chans_ok, bdiv_wrap;
   wire int_rise, int_fall;
   wire tx_ext_rise, tx_ext_fall;
   wire rx_ext_rise, rx_ext_fall;
   wire tx_event, rx_event;
   wire [4:0] tx_bit_idx, rx_bit_idx;
   wire [7:0] tx_sub_idx, rx_sub_idx;
   wire tx_frame, rx_frame;
   wire tx_chclk;
   wire [1:0] mclk_edge;
   wire status_rd;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   bit_sync #(
      .WIDTH(5)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in({rx_chclk_i, rx_bclk_i, tx_bclk_i, rx_mclk_i, tx_mclk_i}),
      .sync_out(pins_s)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_ff <= 5'h00;
      end else begin
         dly_ff <= pins_s;
      end
   end

   assign tx_ext_rise = pins_s[2] & ~dly_ff[2];
   assign tx_ext_fall = ~pins_s[2] & dly_ff[2];
   assign rx_ext_rise = pins_s[3] & ~dly_ff[3];
   assign rx_ext_fall = ~pins_s[3] & dly_ff[3];
   // A master clock faster than pclk/2 aliases; this only proves it is toggling
   assign mclk_edge = pins_s[1:0] ^ dly_ff[1:0];

   // ***************************************************************
   // Internal master and bit clocks
   // ***************************************************************
   assign bdiv_wrap = (bdiv_ff == `BCLK_HALF_LAST);
   assign int_rise = bdiv_wrap & ~bgen_ff;
   assign int_fall = bdiv_wrap & bgen_ff;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mclk_gen_ff <= 1'b0;
         bdiv_ff <= 3'h0;
         bgen_ff <= 1'b0;
      end else begin
         mclk_gen_ff <= ~mclk_gen_ff;
         bdiv_ff <= bdiv_wrap ? 3'h0 : bdiv_ff + 3'h1;
         if (bdiv_wrap) begin
            bgen_ff <= ~bgen_ff;
         end
      end
   end

   // ***************************************************************
   // Bit clock edge selection per side
   // ***************************************************************
   assign tx_event = tx_bdir_ff ? (tx_edge_ff ? tx_ext_fall : tx_ext_rise) :
                     (tx_edge_ff ? int_fall : int_rise);
   assign rx_event = rx_bdir_ff ? (rx_edge_ff ? rx_ext_fall : rx_ext_rise) :
                     (rx_edge_ff ? int_fall : int_rise);

   side_engine u_tx (
      .clk(pclk),
      .rst_n(presetn),
      .bit_event(tx_event),
      .align_en(1'b0),
      .chclk_smp(1'b0),
      .bits_per_subframe(tx_bits_ff),
      .channels_per_frame(tx_chans_ff),
      .channel_pulse_width_select(tx_pulse_ff),
      .channel_clock_polarity_invert(tx_inv_ff),
      .chclk_out(tx_chclk),
      .bit_idx(tx_bit_idx),
      .sub_idx(tx_sub_idx),
      .frame_pulse(tx_frame)
   );

   side_engine u_rx (
      .clk(pclk),
      .rst_n(presetn),
      .bit_event(rx_event),
      .align_en(1'b1),
      .chclk_smp(pins_s[4]),
      .bits_per_subframe(rx_bits_ff),
      .channels_per_frame(rx_chans_ff),
      .channel_pulse_width_select(rx_pulse_ff),
      .channel_clock_polarity_invert(rx_inv_ff),
      .chclk_out(),
      .bit_idx(rx_bit_idx),
      .sub_idx(rx_sub_idx),
      .frame_pulse(rx_frame)
   );

   // ***************************************************************
   // Output enables
   // ***************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_mclk_oe_ff <= 1'b0;
         rx_mclk_oe_ff <= 1'b0;
         tx_bclk_oe_ff <= 1'b0;
         rx_bclk_oe_ff <= 1'b0;
         tx_chclk_oe_ff <= 1'b0;
      end else begin
         tx_mclk_oe_ff <= output_drive_enable_ff & (master_clock_direction_select_ff == `MDIR_TX_OUT);
         rx_mclk_oe_ff <= output_drive_enable_ff & (master_clock_direction_select_ff == `MDIR_RX_OUT);
         tx_bclk_oe_ff <= output_drive_enable_ff & ~tx_bdir_ff;
         rx_bclk_oe_ff <= output_drive_enable_ff & ~rx_bdir_ff;
         tx_chclk_oe_ff <= output_drive_enable_ff;
      end
   end

   // ***************************************************************
   // APB decode and write checks
   // ***************************************************************
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable & pready_ff;
   assign w_bits = pwdata[`CFG_BITS_MSB:`CFG_BITS_LSB];
   assign w_chans = pwdata[`CFG_CHAN_MSB:`CFG_CHAN_LSB];
   assign w_res_tx = pwdata[`RES_TX_MSB:`RES_TX_LSB];
   assign w_res_rx = pwdata[`RES_RX_MSB:`RES_RX_LSB];
   assign tx_bits_ok = (w_bits >= `BITS_MIN) & (w_bits <= `BITS_MAX) & (w_bits >= tx_res_ff);
   assign rx_bits_ok = (w_bits >= `BITS_MIN) & (w_bits <= `BITS_MAX) & (w_bits >= rx_res_ff);
   assign chans_ok = (w_chans >= `CHAN_MIN) & (w_chans <= `CHAN_MAX);
   // Clear at the capture edge so no activity slips between capture and clear
   assign status_rd = setup_ph & ~pwrite & (paddr == `STATUS_OFS);

   always @* begin
      nxt_rdata = 32'h0000_0000;
      nxt_mapped = 1'b1;
      nxt_bad = 1'b0;
      case (paddr)
         `CTRL_OFS: begin
            nxt_rdata = {27'h0, level_ff, output_drive_enable_ff, master_clock_direction_select_ff};
            nxt_bad = (pwdata[`CTRL_MDIR_MSB:`CTRL_MDIR_LSB] > `MDIR_RX_OUT);
         end
         `TX_CFG_OFS: begin
            nxt_rdata = {7'h0, tx_chans_ff, 6'h0, tx_inv_ff, tx_edge_ff, tx_pulse_ff, tx_bdir_ff, tx_bits_ff};
            nxt_bad = ~tx_bits_ok | ~chans_ok;
         end
         `RX_CFG_OFS: begin
            nxt_rdata = {7'h0, rx_chans_ff, 6'h0, rx_inv_ff, rx_edge_ff, rx_pulse_ff, rx_bdir_ff, rx_bits_ff};
            nxt_bad = ~rx_bits_ok | ~chans_ok;
         end
         `RES_OFS: begin
            nxt_rdata = {18'h0, rx_res_ff, 2'h0, tx_res_ff};
            nxt_bad = (w_res_tx > tx_bits_ff) | (w_res_rx > rx_bits_ff);
         end
         `STATUS_OFS: begin
            nxt_rdata = {1'b0, mclk_seen_ff, rx_bit_idx, 3'h0, tx_bit_idx, rx_sub_idx, tx_sub_idx};
            nxt_bad = 1'b1;
         end
         `FRAMES_OFS: begin
            nxt_rdata = {rx_frames_ff, tx_frames_ff};
            nxt_bad = 1'b1;
         end
         default: begin
            nxt_mapped = 1'b0;
         end
      endcase
   end

   // ***************************************************************
   // APB response, one wait-free access phase
   // ***************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup_ph;
         if (setup_ph) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
            pslverr_ff <= ~nxt_mapped | (pwrite & nxt_bad);
         end else begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   // A bad field keeps its old value; good fields of the same write still land
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_clock_direction_select_ff <= `MDIR_BOTH_IN;
         output_drive_enable_ff <= 1'b0;
         level_ff <= 2'h0;
         tx_bits_ff <= `BITS_RST;
         rx_bits_ff <= `BITS_RST;
         tx_chans_ff <= `CHAN_RST;
         rx_chans_ff <= `CHAN_RST;
         {tx_bdir_ff, tx_pulse_ff, tx_edge_ff, tx_inv_ff} <= 4'h0;
         {rx_bdir_ff, rx_pulse_ff, rx_edge_ff, rx_inv_ff} <= 4'h0;
         tx_res_ff <= `RES_RST;
         rx_res_ff <= `RES_RST;
      end else if (access_ph & pwrite) begin
         case (paddr)
            `CTRL_OFS: begin
               if (pwdata[`CTRL_MDIR_MSB:`CTRL_MDIR_LSB] <= `MDIR_RX_OUT) begin
                  master_clock_direction_select_ff <= pwdata[`CTRL_MDIR_MSB:`CTRL_MDIR_LSB];
               end
               output_drive_enable_ff <= pwdata[`CTRL_DRIVE];
               level_ff <= pwdata[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB];
            end
            `TX_CFG_OFS: begin
               if (tx_bits_ok) begin
                  tx_bits_ff <= w_bits;
               end
               if (chans_ok) begin
                  tx_chans_ff <= w_chans;
               end
               tx_bdir_ff <= pwdata[`CFG_BDIR];
               tx_pulse_ff <= pwdata[`CFG_PULSE];
               tx_edge_ff <= pwdata[`CFG_EDGE];
               tx_inv_ff <= pwdata[`CFG_INV];
            end
            `RX_CFG_OFS: begin
               if (rx_bits_ok) begin
                  rx_bits_ff <= w_bits;
               end
               if (chans_ok) begin
                  rx_chans_ff <= w_chans;
               end
               rx_bdir_ff <= pwdata[`CFG_BDIR];
               rx_pulse_ff <= pwdata[`CFG_PULSE];
               rx_edge_ff <= pwdata[`CFG_EDGE];
               rx_inv_ff <= pwdata[`CFG_INV];
            end
            `RES_OFS: begin
               if (w_res_tx <= tx_bits_ff) begin
                  tx_res_ff <= w_res_tx;
               end
               if (w_res_rx <= rx_bits_ff) begin
                  rx_res_ff <= w_res_rx;
               end
            end
            default: begin
               level_ff <= level_ff;
            end
         endcase
      end
   end

   // ***************************************************************
   // Status: frame counts and master clock activity
   // ***************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_frames_ff <= 16'h0000;
         rx_frames_ff <= 16'h0000;
         mclk_seen_ff <= 2'h0;
      end else begin
         if (tx_frame) begin
            tx_frames_ff <= tx_frames_ff + 16'h0001;
         end
         if (rx_frame) begin
            rx_frames_ff <= rx_frames_ff + 16'h0001;
         end
         // Clear on status read; an edge in that same cycle still sets
         mclk_seen_ff[0] <= (mclk_seen_ff[0] & ~status_rd) | (mclk_edge[0] & ~tx_mclk_oe_ff);
         mclk_seen_ff[1] <= (mclk_seen_ff[1] & ~status_rd) | (mclk_edge[1] & ~rx_mclk_oe_ff);
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign tx_mclk_o = mclk_gen_ff;
   assign rx_mclk_o = mclk_gen_ff;
   assign tx_mclk_oe = tx_mclk_oe_ff;
   assign rx_mclk_oe = rx_mclk_oe_ff;
   assign tx_bclk_o = bgen_ff;
   assign rx_bclk_o = bgen_ff;
   assign tx_bclk_oe = tx_bclk_oe_ff;
   assign rx_bclk_oe = rx_bclk_oe_ff;
   assign tx_chclk_o = tx_chclk;
   assign tx_chclk_oe = tx_chclk_oe_ff;
   assign output_level_select = level_ff;

endmodule // audio_clock_top

// ===== audio_clock_chk.sv
// Port-level checks on the serial audio clocking top.
// Assumes every flop runs on pclk and presetn clears them.
module audio_clock_chk (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB handshake
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   // Clock pins
   input wire tx_mclk_o,
   input wire tx_mclk_oe,
   input wire rx_mclk_o,
   input wire rx_mclk_oe,
   input wire tx_bclk_o,
   input wire tx_bclk_oe,
   input wire tx_chclk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ****************************************
   // Assertions
   // ****************************************
   a_mclk_excl: assert property (!(tx_mclk_oe && rx_mclk_oe))
      else $error("both master clocks driven");
   a_tx_mclk_run: assert property (tx_mclk_oe |=> $changed(tx_mclk_o))
      else $error("tx master clock not toggling");
   a_rx_mclk_run: assert property (rx_mclk_oe |=> $changed(rx_mclk_o))
      else $error("rx master clock not toggling");
   a_bclk_half: assert property ($rose(tx_bclk_o) |-> ##4 $fell(tx_bclk_o))
      else $error("bit clock half period wrong");
   // Internal bit clock only: external edges land a few cycles late
   a_chclk_sync: assert property (tx_bclk_oe && $changed(tx_chclk_o) |-> $changed(tx_bclk_o))
      else $error("channel clock off its bit clock edge");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_setup_ready: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
endmodule // audio_clock_chk

bind audio_clock_top audio_clock_chk u_audio_clock_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .tx_mclk_o(tx_mclk_o), .tx_mclk_oe(tx_mclk_oe),
   .rx_mclk_o(rx_mclk_o), .rx_mclk_oe(rx_mclk_oe), .tx_bclk_o(tx_bclk_o), .tx_bclk_oe(tx_bclk_oe),
   .tx_chclk_o(tx_chclk_o));

// ===== audio_partner.sv
// Far-side converter: master clock, bit clock for both sides and channel clock.
// Assumes the block samples these pins with its own clock.
module audio_partner (
   // Control
   input wire logic run,
   // Pins toward the block
   output logic mclk,
   output logic bclk,
   output logic chclk
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BITS = 8;
   int n;
   initial begin
      mclk = 1'b0;
      forever #27 mclk = ~mclk;
   end
   // Bit clock stands still outside traffic
   initial begin
      bclk = 1'b0;
      chclk = 1'b0;
      n = 0;
      forever begin
         #80;
         if (run) begin
            bclk = ~bclk;
            if (!bclk) begin
               chclk = (n == 0);
               n = (n + 1) % BITS;
            end
         end
      end
   end
endmodule // audio_partner

// ===== tb_top.sv
// Self-checking bench for the serial audio clocking top.
// Assumes the partner model supplies both external bit clocks and the receive side pins.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, run, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, q;
   wire [31:0] prdata;
   wire pready, pslverr, tx_mclk_o, tx_mclk_oe, rx_mclk_o, rx_mclk_oe, tx_bclk_o, tx_bclk_oe;
   wire rx_bclk_o, rx_bclk_oe, tx_chclk_o, tx_chclk_oe, mclk, bclk, chclk;
   wire [1:0] lvl;
   int err_total, n_checks;
   audio_clock_top u_audio_clock_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_mclk_i(mclk), .tx_mclk_o(tx_mclk_o), .tx_mclk_oe(tx_mclk_oe), .rx_mclk_i(mclk),
      .rx_mclk_o(rx_mclk_o), .rx_mclk_oe(rx_mclk_oe), .tx_bclk_i(bclk), .tx_bclk_o(tx_bclk_o),
      .tx_bclk_oe(tx_bclk_oe), .rx_bclk_i(bclk), .rx_bclk_o(rx_bclk_o), .rx_bclk_oe(rx_bclk_oe),
      .tx_chclk_o(tx_chclk_o), .tx_chclk_oe(tx_chclk_oe), .rx_chclk_i(chclk), .output_level_select(lvl));
   audio_partner u_audio_partner (.run(run), .mclk(mclk), .bclk(bclk), .chclk(chclk));
   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
      apb(1'b1, a, d);
      chk(e, x);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0002_0020);
      rd(8'h08, 32'h0002_0020);
      rd(8'h0C, 32'h0000_1010);
      wr(8'h18, 32'h1, 1'b1);
      rd(8'h18, 32'h0);
   endtask
   task automatic t_mdir;
      for (int m = 0; m < 3; m++) begin
         wr(8'h00, 32'h4 | m, 1'b0);
         repeat (2) @(posedge pclk);
         chk({tx_mclk_oe, rx_mclk_oe}, (m == 1) ? 2 : ((m == 2) ? 1 : 0));
      end
      wr(8'h00, 32'h7, 1'b1);
      rd(8'h00, 32'h6);
      wr(8'h00, 32'h1, 1'b0);
      repeat (2) @(posedge pclk);
      chk({tx_mclk_oe, rx_mclk_oe, tx_bclk_oe, rx_bclk_oe, tx_chclk_oe}, 0);
      wr(8'h00, 32'h5, 1'b0);
   endtask
   task automatic t_limits;
      wr(8'h04, 32'h0002_000F, 1'b1);
      wr(8'h04, 32'h0002_0021, 1'b1);
      wr(8'h0C, 32'h0000_0808, 1'b0);
      wr(8'h04, 32'h0002_0007, 1'b1);
      wr(8'h04, 32'h0002_0008, 1'b0);
      wr(8'h0C, 32'h0000_0809, 1'b1);
      wr(8'h04, 32'h0000_0008, 1'b1);
      wr(8'h04, 32'h0101_0008, 1'b1);
      wr(8'h04, 32'h0100_0008, 1'b0);
      rd(8'h04, 32'h0100_0008);
   endtask
   task automatic t_shape;
      logic [31:0] cfg [5] = '{32'h0002_0008, 32'h0002_0009, 32'h0002_0088, 32'h0002_0209, 32'h0002_0108};
      logic [31:0] hi [5] = '{8, 8, 2, 10, 8};
      logic [31:0] ones;
      for (int i = 0; i < 5; i++) begin
         wr(8'h04, cfg[i], 1'b0);
         ones = 0;
         // First subframe skipped: counters may still hold the old setting
         repeat (cfg[i][5:0]) @(posedge tx_bclk_o);
         repeat (2 * cfg[i][5:0]) begin
            @(posedge tx_bclk_o);
            @(negedge pclk);
            ones += tx_chclk_o;
         end
         chk(ones, hi[i]);
         @(posedge tx_chclk_o);
         @(negedge pclk);
         chk(tx_bclk_o, !cfg[i][8]);
      end
      chk({tx_bclk_oe, tx_chclk_oe}, 2'b11);
   endtask
   task automatic t_rx;
      logic [31:0] ones;
      wr(8'h08, 32'h0002_0048, 1'b0);
      wr(8'h04, 32'h0002_0048, 1'b0);
      run <= 1'b1;
      repeat (40) @(posedge bclk);
      chk({rx_bclk_oe, tx_bclk_oe}, 0);
      ones = 0;
      // Transmit side now counts on the partner's bit clock
      repeat (16) begin
         @(negedge bclk);
         ones += tx_chclk_o;
      end
      chk(ones, 8);
      apb(1'b0, 8'h10, 32'h0);
      chk({q[30], q[28:24] < 5'd8, q[15:8] < 8'd2}, 3'b111);
      apb(1'b0, 8'h14, 32'h0);
      chk(q[31:16] != 16'h0, 1);
      run <= 1'b0;
   endtask
   // ****************************************
   // Clock, sequence and watchdog
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, run} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_mdir();
      t_limits();
      t_shape();
      t_rx();
      conclude();
   end
   initial begin
      #300000;
      err_total++;
      conclude();
   end
endmodule // tb_top
